//--- core/oscd_consts.vh
// Constants for the orientation sensor command decoder.
// Assumes a 100 MHz core clock; included by bare name.
`ifndef OSCD_CONSTS_VH
`define OSCD_CONSTS_VH
`define OSCD_SYNC0            8'h73
`define OSCD_SYNC1            8'h6e
`define OSCD_SYNC2            8'h70
`define OSCD_CMD_SET_CHAN     8'h80
`define OSCD_CMD_SILENT       8'h81
`define OSCD_CMD_BCAST        8'h82
`define OSCD_CMD_SET_RBIAS    8'h83
`define OSCD_CMD_DEFAULTS     8'h96
`define OSCD_CMD_PERSIST      8'ha0
`define OSCD_CMD_SAMPLE       8'h01
`define OSCD_CMD_Q_CHAN       8'h02
`define OSCD_CMD_Q_MODE       8'h03
`define OSCD_CMD_Q_AOFS       8'h04
`define OSCD_CMD_Q_ROFS       8'h06
`define OSCD_CMD_Q_RSCALE     8'h07
`define OSCD_CMD_Q_BOOTCAL    8'h08
`define OSCD_CMD_Q_FILT       8'h09
`define OSCD_CMD_Q_PNOISE     8'h0c
`define OSCD_CMD_Q_SCOV       8'h0d
`define OSCD_CMD_Q_FMAT       8'h11
`define OSCD_CMD_Q_FOFS       8'h12
`define OSCD_LEN_SET_CHAN     8'h02
`define OSCD_LEN_BCAST        8'h01
`define OSCD_LEN_SET_RBIAS    8'h06
`define OSCD_CHAN_DEFAULT     15'h7fff
`define OSCD_RATE_DEFAULT     8'h00
`define OSCD_BCAST_DEFAULT    1'b1
`define OSCD_CLK_HZ           100000000
`define OSCD_RATE_BASE_HZ     20
`define OSCD_RATE_NUM         280
`define OSCD_RATE_DEN         255
`endif

//--- core/oscd_bcast_timer.v
// Broadcast period timer: one pulse per broadcast interval.
// Assumes one clock; rate value in range 0..255.
`timescale 1ns/1ps
`include "oscd_consts.vh"
module oscd_bcast_timer #(
  parameter CLK_HZ = `OSCD_CLK_HZ
) (
  input  wire        ref_clk_i,
  input  wire        rst_i,
  input  wire        enable_i,
  input  wire        reload_i,
  input  wire [7:0]  rate_i,
  output reg         tick_o
);
  reg  [31:0] count_r;
  wire [31:0] freq_x255;
  wire [31:0] period;
  wire [63:0] period_full;

  // f*255 = 280*x + 20*255; period = CLK*255/(f*255), rounded down
  assign freq_x255 = `OSCD_RATE_NUM * {24'h000000, rate_i}
                     + `OSCD_RATE_BASE_HZ * `OSCD_RATE_DEN;
  assign period_full = 64'd255 * CLK_HZ / {32'h00000000, freq_x255};
  assign period      = period_full[31:0]; // Fits: slowest rate is 20 Hz

  ////////////////////////////////////////////////////////////////
  // Down counter reloaded on mode entry or rate change
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_r <= 32'h00000000;
      tick_o  <= 1'b0;
    end else if (!enable_i || reload_i) begin
      count_r <= period - 32'h00000001;
      tick_o  <= 1'b0;
    end else if (count_r == 32'h00000000) begin
      count_r <= period - 32'h00000001;
      tick_o  <= 1'b1;
    end else begin
      count_r <= count_r - 32'h00000001;
      tick_o  <= 1'b0;
    end
  end
endmodule

//--- core/oscd_decoder.v
// Command packet decoder for an orientation sensor UART link.
// Assumes received bytes arrive as strobes synchronous to ref_clk_i.
// Function
// - Packet is 'snp', type, length, that many data bytes, two sum bytes.
// - Sum is of all earlier bytes; mismatch gets a bad-sum reply.
// - Unknown type byte gets an unrecognized-command reply.
// - 0x96 restores all settings to defaults.
// - 0xa0 saves present configuration to nonvolatile storage.
// - 0x01 in silent mode sends one sample packet of active channels.
// - Only active channels are measured and sent.
// - 0x02 replies with the active channel list.
// - 0x03 replies with broadcast or silent mode.
// - 0x04 replies with accelerometer offsets.
// - 0x06 replies with rate gyro offsets.
// - 0x07 replies with rate gyro scale factors.
// - 0x08 replies with boot calibration enable.
// - 0x09 replies with filter configuration byte.
// - 0x0c replies with process noise variance.
// - 0x0d replies with state covariance matrix.
// - 0x11 and 0x12 reply with field matrix and field offset.
// - 0x80 carries two bytes of channel selection bits.
// - Bit one activates a channel, zero deactivates it.
// - 0x81 enters silent mode.
// - Commands without data have length zero, sum follows directly.
// - 0x82 with one byte enters broadcast mode.
// - Broadcast rate is 280/255 times value plus 20 Hz.
// - 0x83 carries three signed 16-bit gyro offsets.
// - Gyro offset pairs are Z, then Y, then X.
`timescale 1ns/1ps
`include "oscd_consts.vh"
module oscd_decoder #(
  parameter CLK_HZ = `OSCD_CLK_HZ
) (
  // Clock and reset
  input  wire        ref_clk_i,
  input  wire        rst_i,
  // Received byte stream
  input  wire        rx_valid_i,
  input  wire [7:0]  rx_byte_i,
  // Reply and error events
  output reg         reply_valid_o,
  output reg  [7:0]  reply_kind_o,
  output reg         bad_sum_o,
  output reg         unknown_cmd_o,
  output reg         sample_req_o,
  // Transmit configuration
  output wire [14:0] active_chan_o,
  output wire        bcast_mode_o,
  output wire [7:0]  bcast_rate_o,
  // Gyro offsets and storage events
  output reg  [15:0] rate_z_bias_o,
  output reg  [15:0] rate_y_bias_o,
  output reg  [15:0] rate_x_bias_o,
  output reg         rate_bias_wr_o,
  output reg         restore_defaults_o,
  output reg         persist_config_o
);
  localparam S_SYNC0 = 3'd0;
  localparam S_SYNC1 = 3'd1;
  localparam S_SYNC2 = 3'd2;
  localparam S_TYPE  = 3'd3;
  localparam S_LEN   = 3'd4;
  localparam S_DATA  = 3'd5;
  localparam S_SUMHI = 3'd6;
  localparam S_SUMLO = 3'd7;

  // Frame state and captured bytes
  reg  [2:0]  state_r;
  reg  [7:0]  type_r;
  reg  [7:0]  len_r;
  reg  [7:0]  idx_r;
  reg  [15:0] sum_r;
  reg  [7:0]  sum_hi_r;
  reg  [7:0]  data_r [0:5];
  // Stored transmit settings
  reg  [14:0] chan_r;
  reg         bcast_r;
  reg  [7:0]  rate_r;
  reg         reload_r;
  // Timer tick and sum check
  wire        tick;
  wire [15:0] rx_sum;
  wire        sum_ok;
  wire [5:0]  data_we;
  integer     i;
  genvar      g;

  // Known query codes that yield a report packet
  function is_query;
    input [7:0] t;
    begin
      case (t)
        `OSCD_CMD_Q_CHAN, `OSCD_CMD_Q_MODE, `OSCD_CMD_Q_AOFS,
        `OSCD_CMD_Q_ROFS, `OSCD_CMD_Q_RSCALE, `OSCD_CMD_Q_BOOTCAL,
        `OSCD_CMD_Q_FILT, `OSCD_CMD_Q_PNOISE, `OSCD_CMD_Q_SCOV,
        `OSCD_CMD_Q_FMAT, `OSCD_CMD_Q_FOFS: is_query = 1'b1;
        default: is_query = 1'b0;
      endcase
    end
  endfunction

  // Every code this block acts on
  function is_known;
    input [7:0] t;
    begin
      case (t)
        `OSCD_CMD_SET_CHAN, `OSCD_CMD_SILENT, `OSCD_CMD_BCAST,
        `OSCD_CMD_SET_RBIAS, `OSCD_CMD_DEFAULTS, `OSCD_CMD_PERSIST,
        `OSCD_CMD_SAMPLE: is_known = 1'b1;
        default: is_known = is_query(t);
      endcase
    end
  endfunction

  // Length that a setter must carry; other codes take any length
  function len_match;
    input [7:0] t;
    input [7:0] n;
    begin
      case (t)
        `OSCD_CMD_SET_CHAN:  len_match = (n == `OSCD_LEN_SET_CHAN);
        `OSCD_CMD_BCAST:     len_match = (n == `OSCD_LEN_BCAST);
        `OSCD_CMD_SET_RBIAS: len_match = (n == `OSCD_LEN_SET_RBIAS);
        default:             len_match = 1'b1;
      endcase
    end
  endfunction

  // Sum check and level outputs
  assign rx_sum        = {sum_hi_r, rx_byte_i};
  assign sum_ok        = (rx_sum == sum_r);
  assign active_chan_o = chan_r;
  assign bcast_mode_o  = bcast_r;
  assign bcast_rate_o  = rate_r;

  // One write enable per stored data byte
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_data_we
      localparam [7:0] BYTE_IDX = g;
      assign data_we[g] = rx_valid_i && (state_r == S_DATA) && (idx_r == BYTE_IDX);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // Packet framing and running sum
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r  <= S_SYNC0;
      type_r   <= 8'h00;
      len_r    <= 8'h00;
      idx_r    <= 8'h00;
      sum_r    <= 16'h0000;
      sum_hi_r <= 8'h00;
      for (i = 0; i < 6; i = i + 1)
        data_r[i] <= 8'h00;
    end else if (rx_valid_i) begin
      case (state_r)
        // Hunt for the first sync byte
        S_SYNC0: begin
          sum_r   <= {8'h00, rx_byte_i};
          state_r <= (rx_byte_i == `OSCD_SYNC0) ? S_SYNC1 : S_SYNC0;
        end
        // Second sync byte or restart the hunt
        S_SYNC1: begin
          sum_r   <= sum_r + {8'h00, rx_byte_i};
          state_r <= (rx_byte_i == `OSCD_SYNC1) ? S_SYNC2 : S_SYNC0;
        end
        // Third sync byte or restart the hunt
        S_SYNC2: begin
          sum_r   <= sum_r + {8'h00, rx_byte_i};
          state_r <= (rx_byte_i == `OSCD_SYNC2) ? S_TYPE : S_SYNC0;
        end
        // Type byte kept for execution
        S_TYPE: begin
          sum_r   <= sum_r + {8'h00, rx_byte_i};
          type_r  <= rx_byte_i;
          state_r <= S_LEN;
        end
        // Length byte; zero skips to the sum
        S_LEN: begin
          sum_r   <= sum_r + {8'h00, rx_byte_i};
          len_r   <= rx_byte_i;
          idx_r   <= 8'h00;
          state_r <= (rx_byte_i == 8'h00) ? S_SUMHI : S_DATA;
        end
        // Data bytes counted against the length
        S_DATA: begin
          sum_r <= sum_r + {8'h00, rx_byte_i};
          // Only the first six data bytes are kept
          for (i = 0; i < 6; i = i + 1)
            if (data_we[i])
              data_r[i] <= rx_byte_i;
          idx_r <= idx_r + 8'h01;
          if (idx_r + 8'h01 == len_r)
            state_r <= S_SUMHI;
        end
        // High sum byte held for the compare
        S_SUMHI: begin
          sum_hi_r <= rx_byte_i;
          state_r  <= S_SUMLO;
        end
        // Low sum byte closes the packet
        S_SUMLO: state_r <= S_SYNC0;
        default: state_r <= S_SYNC0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Command execution on the last sum byte
  wire done = rx_valid_i && (state_r == S_SUMLO);
  wire good = done && sum_ok && is_known(type_r);
  // Setters with a wrong length are dropped silently
  wire len_ok = len_match(type_r, len_r);

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      chan_r             <= `OSCD_CHAN_DEFAULT;
      bcast_r            <= `OSCD_BCAST_DEFAULT;
      rate_r             <= `OSCD_RATE_DEFAULT;
      reload_r           <= 1'b0;
      reply_valid_o      <= 1'b0;
      reply_kind_o       <= 8'h00;
      bad_sum_o          <= 1'b0;
      unknown_cmd_o      <= 1'b0;
      sample_req_o       <= 1'b0;
      rate_z_bias_o      <= 16'h0000;
      rate_y_bias_o      <= 16'h0000;
      rate_x_bias_o      <= 16'h0000;
      rate_bias_wr_o     <= 1'b0;
      restore_defaults_o <= 1'b0;
      persist_config_o   <= 1'b0;
    end else begin
      // Pulses default low
      reload_r           <= 1'b0;
      reply_valid_o      <= 1'b0;
      bad_sum_o          <= done && !sum_ok;
      unknown_cmd_o      <= done && sum_ok && !is_known(type_r);
      rate_bias_wr_o     <= 1'b0;
      restore_defaults_o <= 1'b0;
      persist_config_o   <= 1'b0;
      // Sample on request in silent mode or on timer tick in broadcast mode
      sample_req_o <= (good && type_r == `OSCD_CMD_SAMPLE && !bcast_r)
                      || (tick && bcast_r);
      // Report packet for every known query
      if (good && is_query(type_r)) begin
        reply_valid_o <= 1'b1;
        reply_kind_o  <= type_r;
      end
      // Settings changed by a good packet
      if (good) begin
        case (type_r)
          // Channel mask from both data bytes
          `OSCD_CMD_SET_CHAN: if (len_ok)
            chan_r <= {data_r[0], data_r[1][7:1]};
          // Silent mode stops the timer
          `OSCD_CMD_SILENT: bcast_r <= 1'b0;
          // Broadcast mode with a new rate
          `OSCD_CMD_BCAST: if (len_ok) begin
            bcast_r  <= 1'b1;
            rate_r   <= data_r[0];
            reload_r <= 1'b1;
          end
          // Gyro offsets, high byte first
          `OSCD_CMD_SET_RBIAS: if (len_ok) begin
            rate_z_bias_o  <= {data_r[0], data_r[1]};
            rate_y_bias_o  <= {data_r[2], data_r[3]};
            rate_x_bias_o  <= {data_r[4], data_r[5]};
            rate_bias_wr_o <= 1'b1;
          end
          // Every setting back to its default
          `OSCD_CMD_DEFAULTS: begin
            chan_r             <= `OSCD_CHAN_DEFAULT;
            bcast_r            <= `OSCD_BCAST_DEFAULT;
            rate_r             <= `OSCD_RATE_DEFAULT;
            reload_r           <= 1'b1;
            rate_z_bias_o      <= 16'h0000;
            rate_y_bias_o      <= 16'h0000;
            rate_x_bias_o      <= 16'h0000;
            restore_defaults_o <= 1'b1;
          end
          // Storage request for the present settings
          `OSCD_CMD_PERSIST: persist_config_o <= 1'b1;
          default: reload_r <= 1'b0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Broadcast interval timer
  oscd_bcast_timer #(.CLK_HZ(CLK_HZ)) u_timer (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .enable_i  (bcast_r),
    .reload_i  (reload_r),
    .rate_i    (rate_r),
    .tick_o    (tick)
  );
endmodule

//--- tb/oscd_host_model.sv
// Host model: sends command packets one byte per clock.
// Assumes the decoder takes a byte on a rising edge with valid.
`timescale 1ns/1ps
`include "oscd_consts.vh"
module oscd_host_model (
  input  wire        ref_clk_i,
  output logic       rx_valid_o,
  output logic [7:0] rx_byte_o
);
  // Idle line at time zero
  initial begin
    rx_valid_o = 1'b0;
    rx_byte_o  = 8'h00;
  end
  ////////////////////////////////////////
  // One byte per clock, changed on the falling edge
  task automatic put(input logic [7:0] b);
    @(negedge ref_clk_i);
    rx_valid_o = 1'b1;
    rx_byte_o  = b;
  endtask
  // Sync, type, length, data, sum high then low
  task automatic send(input logic [7:0] t, n, input logic [47:0] d, input logic bad);
    logic [39:0] hd = {`OSCD_SYNC0, `OSCD_SYNC1, `OSCD_SYNC2, t, n};
    logic [15:0] s;
    logic [7:0]  b;
    int          i;
    s = 16'h0000;
    for (i = 0; i < n + 5; i++) begin
      b = i < 5 ? hd[39 - 8 * i -: 8] : d[87 - 8 * i -: 8];
      s = s + b;
      put(b);
    end
    s = s ^ {15'h0000, bad}; // Corrupt the sum on request
    put(s[15:8]);
    put(s[7:0]);
    @(negedge ref_clk_i);
    rx_valid_o = 1'b0;
    rx_byte_o  = ~rx_byte_o; // Released line shows the inverse
  endtask
endmodule

//--- tb/oscd_props.sv
// Checker on the decoder ports.
// Assumes binding into every decoder instance.
`timescale 1ns/1ps
module oscd_props #(
  parameter CLK_HZ = 25500
) (
  input wire       ref_clk_i,
  input wire       rst_i,
  input wire       rx_valid_i,
  input wire       reply_valid_o,
  input wire [7:0] reply_kind_o,
  input wire       bad_sum_o,
  input wire       unknown_cmd_o,
  input wire       sample_req_o,
  input wire       bcast_mode_o,
  input wire [7:0] bcast_rate_o,
  input wire       rate_bias_wr_o,
  input wire       restore_defaults_o,
  input wire       persist_config_o
);
  logic [2:0] rv_r = 3'h0;
  // Bytes taken at the last three edges
  always @(posedge ref_clk_i) rv_r <= {rv_r[1:0], rx_valid_i};
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  property p_bad; bad_sum_o |-> !unknown_cmd_o && !reply_valid_o && |rv_r; endproperty
  a_bad: assert property (p_bad) else $error("bad sum with other event");
  property p_unk; unknown_cmd_o |-> |rv_r && !rate_bias_wr_o && !restore_defaults_o; endproperty
  a_unk: assert property (p_unk) else $error("unknown type acted on");
  property p_rep; reply_valid_o |-> |rv_r ##1 !reply_valid_o; endproperty
  a_rep: assert property (p_rep) else $error("reply pulse misplaced");
  property p_kind;
    reply_valid_o |-> reply_kind_o inside {8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08,
                                           8'h09, 8'h0c, 8'h0d, 8'h11, 8'h12};
  endproperty
  a_kind: assert property (p_kind) else $error("reply kind invalid");
  property p_smp; sample_req_o && !bcast_mode_o |-> |rv_r; endproperty
  a_smp: assert property (p_smp) else $error("unrequested sample in silent");
  property p_bias; rate_bias_wr_o |-> |rv_r ##1 !rate_bias_wr_o; endproperty
  a_bias: assert property (p_bias) else $error("bias write pulse misplaced");
  property p_rst; restore_defaults_o |-> |rv_r && !persist_config_o; endproperty
  a_rst: assert property (p_rst) else $error("restore pulse misplaced");
  property p_pers; persist_config_o |-> |rv_r ##1 !persist_config_o; endproperty
  a_pers: assert property (p_pers) else $error("persist pulse misplaced");
  property p_mode; $changed(bcast_mode_o) |-> |rv_r; endproperty
  a_mode: assert property (p_mode) else $error("mode changed without command");
  property p_rate; $changed(bcast_rate_o) |-> |rv_r; endproperty
  a_rate: assert property (p_rate) else $error("rate changed without command");
  c_rep: cover property (reply_valid_o);
  c_bias: cover property (rate_bias_wr_o);
  c_bcast: cover property (sample_req_o && bcast_mode_o);
endmodule
bind oscd_decoder oscd_props #(.CLK_HZ(CLK_HZ)) u_props (.ref_clk_i, .rst_i, .rx_valid_i,
  .reply_valid_o, .reply_kind_o, .bad_sum_o, .unknown_cmd_o, .sample_req_o, .bcast_mode_o,
  .bcast_rate_o, .rate_bias_wr_o, .restore_defaults_o, .persist_config_o);

//--- tb/tb_top.sv
// Self-checking bench for the command decoder.
// Assumes the host model drives the byte strobe.
`timescale 1ns/1ps
module tb_top;
  localparam int CLK = 25500;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  wire rx_valid_i, reply_valid_o, bad_sum_o, unknown_cmd_o, sample_req_o, bcast_mode_o;
  wire rate_bias_wr_o, restore_defaults_o, persist_config_o;
  wire [7:0] rx_byte_i, reply_kind_o, bcast_rate_o;
  wire [14:0] active_chan_o;
  wire [15:0] rate_z_bias_o, rate_y_bias_o, rate_x_bias_o;
  logic [6:0] seen = 7'h00;
  int miscompares = 0;
  int n_checks = 0;
  oscd_host_model h (.ref_clk_i, .rx_valid_o(rx_valid_i), .rx_byte_o(rx_byte_i));
  oscd_decoder #(.CLK_HZ(CLK)) DUT (.ref_clk_i, .rst_i, .rx_valid_i, .rx_byte_i,
    .reply_valid_o, .reply_kind_o, .bad_sum_o, .unknown_cmd_o, .sample_req_o,
    .active_chan_o, .bcast_mode_o, .bcast_rate_o, .rate_z_bias_o, .rate_y_bias_o,
    .rate_x_bias_o, .rate_bias_wr_o, .restore_defaults_o, .persist_config_o);
  ////////////////////////////////////////
  // Clock and pulse capture
  always #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) seen <= seen | {reply_valid_o, bad_sum_o, unknown_cmd_o,
    sample_req_o, rate_bias_wr_o, restore_defaults_o, persist_config_o};
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Send one packet, compare pulses other than sample
  task automatic cmd(input logic [7:0] t, n, input logic [47:0] d, input logic b, input logic [6:0] ex);
    seen = 7'h00;
    h.send(t, n, d, b);
    repeat (4) @(negedge ref_clk_i);
    chk(seen & 7'h77, ex);
  endtask
  task automatic wait_smp(output logic [15:0] p);
    p = 0;
    do begin
      @(posedge ref_clk_i) #1;
      p++;
    end while (sample_req_o !== 1'b1 && p < 16'd3000);
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    chk(active_chan_o, 15'h7fff);
    chk(bcast_mode_o, 1'b1);
    chk(rate_x_bias_o, 16'h0000);
  endtask
  task automatic t_silent;
    cmd(8'h81, 8'h00, 48'h0, 1'b0, 7'h00);
    chk(bcast_mode_o, 1'b0);
    cmd(8'h01, 8'h00, 48'h0, 1'b0, 7'h00);
    chk(seen[3], 1'b1);
  endtask
  task automatic t_query;
    logic [7:0] q [11] = '{8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0c, 8'h0d,
                           8'h11, 8'h12};
    for (int i = 0; i < 11; i++) begin
      cmd(q[i], 8'h00, 48'h0, 1'b0, 7'h40);
      chk(reply_kind_o, q[i]);
    end
  endtask
  task automatic t_chan;
    cmd(8'h80, 8'h02, {16'ha53c, 32'h0}, 1'b0, 7'h00);
    chk(active_chan_o, {8'ha5, 7'h1e});
    cmd(8'h80, 8'h01, {8'h00, 40'h0}, 1'b0, 7'h00);
    chk(active_chan_o, {8'ha5, 7'h1e});
  endtask
  task automatic t_bias;
    cmd(8'h83, 8'h06, 48'h1234_5678_9abc, 1'b0, 7'h04);
    chk(rate_z_bias_o, 16'h1234);
    chk(rate_y_bias_o, 16'h5678);
    chk(rate_x_bias_o, 16'h9abc);
    cmd(8'h83, 8'h02, {16'hffff, 32'h0}, 1'b0, 7'h00);
    chk(rate_z_bias_o, 16'h1234);
  endtask
  task automatic t_bad;
    cmd(8'h80, 8'h02, 48'h0, 1'b1, 7'h20);
    chk(active_chan_o, {8'ha5, 7'h1e});
    cmd(8'h7f, 8'h00, 48'h0, 1'b0, 7'h10);
  endtask
  task automatic t_bcast;
    logic [15:0] p;
    logic [7:0]  x;
    for (int k = 0; k < 2; k++) begin
      x = k ? 8'hff : 8'h00;
      cmd(8'h82, 8'h01, {x, 40'h0}, 1'b0, 7'h00);
      chk(bcast_mode_o, 1'b1);
      chk(bcast_rate_o, x);
      wait_smp(p);
      wait_smp(p);
      chk(p, 16'(CLK * 255 / (280 * x + 5100)));
    end
  endtask
  task automatic t_restore;
    cmd(8'h96, 8'h00, 48'h0, 1'b0, 7'h02);
    chk(active_chan_o, 15'h7fff);
    chk(bcast_rate_o, 8'h00);
    chk(rate_z_bias_o, 16'h0000);
    cmd(8'ha0, 8'h00, 48'h0, 1'b0, 7'h01);
  endtask
  // Reset in mid-run, then a request in broadcast mode
  task automatic t_midreset;
    cmd(8'h80, 8'h02, {16'h0102, 32'h0}, 1'b0, 7'h00);
    chk(active_chan_o, {8'h01, 7'h01});
    @(negedge ref_clk_i);
    rst_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    rst_i = 1'b0;
    t_reset();
    cmd(8'h02, 8'h00, 48'h0, 1'b0, 7'h40);
    cmd(8'h01, 8'h00, 48'h0, 1'b0, 7'h00);
    chk(seen[3], 1'b0);
  endtask
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(negedge ref_clk_i);
    rst_i = 1'b0;
    t_reset();
    t_silent();
    t_query();
    t_chan();
    t_bias();
    t_bad();
    t_bcast();
    t_restore();
    t_midreset();
    end_of_test();
  end
  // Watchdog
  initial begin
    #200us;
    miscompares++;
    end_of_test();
  end
endmodule
